// *** rtl/rsp_pkg.sv ***
// Constants shared by the two-wire serial port: frame layout, baud limits, timing.
// Assumes a single 20 MHz system clock drives every file that imports it.
`default_nettype none
package rsp_pkg;
    localparam int unsigned CLOCK_HZ      = 20_000_000;
    localparam int unsigned BAUD_MIN      = 300;
    localparam int unsigned BAUD_MAX      = 250_000;
    localparam int unsigned DATA_BITS     = 8;
    // Divider for 16x oversampling: clocks per sixteenth of a bit
    localparam int unsigned OVS           = 16;
    localparam int unsigned DIV_MIN       = CLOCK_HZ / (BAUD_MAX * OVS);
    localparam int unsigned DIV_MAX       = CLOCK_HZ / (BAUD_MIN * OVS);
    localparam int unsigned DIV_W         = 16;
    localparam logic [15:0] DIV_RESET     = 16'h0005; // 250 kbaud at reset
    localparam logic [3:0]  OVS_MID       = 4'h7;     // Tick at bit centre
    localparam logic [3:0]  OVS_LAST      = 4'hF;
    localparam logic        START_LEVEL   = 1'b0;
    localparam logic        STOP_LEVEL    = 1'b1;
    localparam int unsigned BUF_DEPTH     = 16;
endpackage
`default_nettype wire

// *** rtl/rsp_baud_gen.sv ***
// Baud tick divider: one-cycle pulse at sixteen times the bit rate.
// Assumes the divisor input is held stable by the parent between changes.
`timescale 1ns/100ps
`default_nettype none
module rsp_baud_gen
    import rsp_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [DIV_W-1:0] divisor,
    output var  logic             tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             tick_d;

    // Count down, reload on zero; divisor of zero behaves as one
    always_comb begin
        tick_d = (cnt_q == '0);
        cnt_d  = tick_d ? (divisor == '0 ? '0 : divisor - 1'b1) : cnt_q - 1'b1;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule
`default_nettype wire

// *** rtl/rsp_serial_port.sv ***
// Two-wire serial port: 8N1 transmitter, receiver, optional receive buffer, driver control.
// Assumes an external transceiver; all inputs synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Frames carry eight data bits, no parity, one stop bit.
// - Shared baud divisor covers 300 to 250K baud.
// - Start bit drives 0, stop bit drives 1.
// - Frame is start, eight data, stop, nothing else.
// - Data sent and received least significant bit first.
// - Receiver and transmitter run independently, full duplex.
// - Single-byte receive or background buffered receive mode.
// - Same port carries bus traffic and programming traffic.
// - Turnaround is input only, driven by host in slave mode.
// - Active-low external reset resets the whole block.
module rsp_serial_port
    import rsp_pkg::*;
#(
    parameter int unsigned DEPTH = BUF_DEPTH
)(
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [DIV_W-1:0] baud_divisor,
    input  wire logic             master_mode,
    input  wire logic             buffered_mode,
    input  wire logic             turnaround,
    input  wire logic             serial_receive_line,
    output var  logic             serial_transmit_line,
    output var  logic             driver_enable,
    input  wire logic             tx_valid,
    input  wire logic [7:0]       tx_data,
    output var  logic             tx_ready,
    output var  logic             rx_valid,
    output var  logic [7:0]       rx_data,
    input  wire logic             rx_ready,
    output var  logic             rx_framing_error,
    output var  logic             rx_overrun
);
    localparam int unsigned AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("DEPTH must be a power of two, at least 2");
    end

    typedef enum logic [1:0] {RSP_IDLE, RSP_START, RSP_DATA, RSP_STOP} rsp_state_type;

    // Shared divisor clamped to the supported rate span
    logic [DIV_W-1:0] div_use;
    logic             tick;
    always_comb begin
        div_use = baud_divisor;
        if (baud_divisor < DIV_W'(DIV_MIN)) div_use = DIV_W'(DIV_MIN);
        if (baud_divisor > DIV_W'(DIV_MAX)) div_use = DIV_W'(DIV_MAX);
    end

    rsp_baud_gen u_baud (
        .clock   (clock),
        .rst_b   (rst_b),
        .divisor (div_use),
        .tick    (tick)
    );

    // ---------------- Transmitter ----------------
    rsp_state_type tx_st_q, tx_st_d;
    logic [3:0]    tx_ovs_q, tx_ovs_d;
    logic [2:0]    tx_bit_q, tx_bit_d;
    logic [7:0]    tx_sh_q, tx_sh_d;
    logic          tx_line_d, tx_rdy_d;

    // Frame sequencer; line held at stop level when idle
    always_comb begin
        tx_st_d   = tx_st_q;
        tx_ovs_d  = tx_ovs_q;
        tx_bit_d  = tx_bit_q;
        tx_sh_d   = tx_sh_q;
        tx_line_d = serial_transmit_line;
        tx_rdy_d  = tx_ready;
        case (tx_st_q)
            RSP_IDLE: begin
                tx_line_d = STOP_LEVEL;
                if (tx_valid && tx_ready) begin
                    tx_sh_d   = tx_data;
                    tx_rdy_d  = 1'b0;
                    tx_ovs_d  = '0;
                    tx_st_d   = RSP_START;
                    tx_line_d = START_LEVEL;
                end
            end
            RSP_START: begin
                if (tick) begin
                    tx_ovs_d = tx_ovs_q + 1'b1;
                    if (tx_ovs_q == OVS_LAST) begin
                        tx_st_d   = RSP_DATA;
                        tx_bit_d  = '0;
                        tx_line_d = tx_sh_q[0];
                    end
                end
            end
            RSP_DATA: begin
                if (tick) begin
                    tx_ovs_d = tx_ovs_q + 1'b1;
                    if (tx_ovs_q == OVS_LAST) begin
                        tx_sh_d  = {1'b0, tx_sh_q[7:1]};
                        tx_bit_d = tx_bit_q + 1'b1;
                        if (tx_bit_q == 3'(DATA_BITS - 1)) begin
                            tx_st_d   = RSP_STOP;
                            tx_line_d = STOP_LEVEL;
                        end else begin
                            tx_line_d = tx_sh_q[1];
                        end
                    end
                end
            end
            RSP_STOP: begin
                if (tick && tx_ovs_q == OVS_LAST) begin
                    tx_st_d  = RSP_IDLE;
                    tx_rdy_d = 1'b1;
                end else if (tick) begin
                    tx_ovs_d = tx_ovs_q + 1'b1;
                end
            end
            default: tx_st_d = RSP_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q              <= RSP_IDLE;
            tx_ovs_q             <= '0;
            tx_bit_q             <= '0;
            tx_sh_q              <= '0;
            serial_transmit_line <= STOP_LEVEL;
            tx_ready             <= 1'b1;
        end else begin
            tx_st_q              <= tx_st_d;
            tx_ovs_q             <= tx_ovs_d;
            tx_bit_q             <= tx_bit_d;
            tx_sh_q              <= tx_sh_d;
            serial_transmit_line <= tx_line_d;
            tx_ready             <= tx_rdy_d;
        end
    end

    // Driver enable: host steers it in slave mode, own activity as master
    logic de_d;
    always_comb begin
        if (master_mode) de_d = (tx_st_d != RSP_IDLE);
        else             de_d = turnaround;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) driver_enable <= 1'b0;
        else        driver_enable <= de_d;
    end

    // ---------------- Receiver (independent of transmitter) ----------------
    rsp_state_type rx_st_q, rx_st_d;
    logic [3:0]    rx_ovs_q, rx_ovs_d;
    logic [2:0]    rx_bit_q, rx_bit_d;
    logic [7:0]    rx_sh_q, rx_sh_d;
    logic          rx_prev_q;
    logic          byte_done, frame_err_ev;

    // Start edge, centre sampling, stop check; same port for any traffic
    always_comb begin
        rx_st_d      = rx_st_q;
        rx_ovs_d     = rx_ovs_q;
        rx_bit_d     = rx_bit_q;
        rx_sh_d      = rx_sh_q;
        byte_done    = 1'b0;
        frame_err_ev = 1'b0;
        case (rx_st_q)
            RSP_IDLE: begin
                if (rx_prev_q && !serial_receive_line) begin
                    rx_st_d  = RSP_START;
                    rx_ovs_d = '0;
                end
            end
            RSP_START: begin
                if (tick) begin
                    rx_ovs_d = rx_ovs_q + 1'b1;
                    if (rx_ovs_q == OVS_MID) begin
                        // Glitch shorter than half a bit is not a start
                        if (serial_receive_line != START_LEVEL) rx_st_d = RSP_IDLE;
                        else begin
                            rx_st_d  = RSP_DATA;
                            rx_ovs_d = '0;
                            rx_bit_d = '0;
                        end
                    end
                end
            end
            RSP_DATA: begin
                if (tick) begin
                    rx_ovs_d = rx_ovs_q + 1'b1;
                    if (rx_ovs_q == OVS_LAST) begin
                        rx_sh_d  = {serial_receive_line, rx_sh_q[7:1]};
                        rx_bit_d = rx_bit_q + 1'b1;
                        if (rx_bit_q == 3'(DATA_BITS - 1)) rx_st_d = RSP_STOP;
                    end
                end
            end
            RSP_STOP: begin
                if (tick) begin
                    rx_ovs_d = rx_ovs_q + 1'b1;
                    if (rx_ovs_q == OVS_LAST) begin
                        rx_st_d      = RSP_IDLE;
                        byte_done    = (serial_receive_line == STOP_LEVEL);
                        frame_err_ev = (serial_receive_line != STOP_LEVEL);
                    end
                end
            end
            default: rx_st_d = RSP_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q   <= RSP_IDLE;
            rx_ovs_q  <= '0;
            rx_bit_q  <= '0;
            rx_sh_q   <= '0;
            rx_prev_q <= 1'b1;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_ovs_q  <= rx_ovs_d;
            rx_bit_q  <= rx_bit_d;
            rx_sh_q   <= rx_sh_d;
            rx_prev_q <= serial_receive_line;
        end
    end

    // ---------------- Receive holding: single byte or buffered ----------------
    logic [7:0]  buf_mem [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic        full, empty, pop, push;
    logic        rxv_d, fe_d, ov_d;
    logic [7:0]  rxd_d;

    // Single-byte mode uses one slot; buffered mode fills the whole array
    always_comb begin
        empty = (wr_q == rd_q);
        full  = buffered_mode ? (wr_q - rd_q == (AW+1)'(DEPTH)) : !empty;
        pop   = rx_valid && rx_ready;
        push  = byte_done && !full;
        wr_d  = wr_q + (AW+1)'(push);
        rd_d  = rd_q + (AW+1)'(pop);
        rxv_d = (wr_d != rd_d);
        rxd_d = (wr_d != rd_d) ? ((push && empty) || (pop && rd_d == wr_q) ? rx_sh_q
                                                 : buf_mem[rd_d[AW-1:0]]) : rx_data;
        fe_d  = rx_framing_error | frame_err_ev; // Sticky until reset
        ov_d  = rx_overrun | (byte_done && full);
    end

    always_ff @(posedge clock) begin
        if (push) buf_mem[wr_q[AW-1:0]] <= rx_sh_q;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_q             <= '0;
            rd_q             <= '0;
            rx_valid         <= 1'b0;
            rx_data          <= '0;
            rx_framing_error <= 1'b0;
            rx_overrun       <= 1'b0;
        end else begin
            wr_q             <= wr_d;
            rd_q             <= rd_d;
            rx_valid         <= rxv_d;
            rx_data          <= rxd_d;
            rx_framing_error <= fe_d;
            rx_overrun       <= ov_d;
        end
    end

    // Checks
    sequence s_tx_accept;
        tx_valid && tx_ready;
    endsequence

    a_tx_start_low: assert property (@(posedge clock) disable iff (!rst_b)
        s_tx_accept |=> !serial_transmit_line && !tx_ready)
        else $error("start bit not driven low");
    a_tx_idle_high: assert property (@(posedge clock) disable iff (!rst_b)
        tx_st_q == RSP_IDLE && $past(tx_st_q) == RSP_IDLE |-> serial_transmit_line)
        else $error("idle line not high");
    a_tx_stop_high: assert property (@(posedge clock) disable iff (!rst_b)
        tx_st_q == RSP_STOP |-> serial_transmit_line)
        else $error("stop bit not high");
    a_slave_dir: assert property (@(posedge clock) disable iff (!rst_b)
        !master_mode |=> driver_enable == $past(turnaround))
        else $error("driver enable not following turnaround");
    a_rx_ferr: assert property (@(posedge clock) disable iff (!rst_b)
        frame_err_ev |=> rx_framing_error)
        else $error("framing error not flagged");
    a_rx_deliver: assert property (@(posedge clock) disable iff (!rst_b)
        byte_done && !full |=> rx_valid)
        else $error("received byte not presented");
    a_div_range: assert property (@(posedge clock) disable iff (!rst_b)
        div_use >= DIV_W'(DIV_MIN) && div_use <= DIV_W'(DIV_MAX))
        else $error("divisor outside rate span");
    a_tx_data_lsb: assert property (@(posedge clock) disable iff (!rst_b)
        tx_st_q == RSP_START && tx_st_d == RSP_DATA |=> serial_transmit_line == $past(tx_sh_q[0]))
        else $error("first data bit not LSB");
endmodule
`default_nettype wire

// *** sim/rsp_node_model.sv ***
// Far-side bus node: sends and captures 8N1 frames on the two serial lines.
// Assumes the bench calls its tasks; bit length given in system clocks.
`timescale 1ns/100ps
`default_nettype none
module rsp_node_model (
    input  wire logic clock,
    input  wire logic tx_line,
    output var  logic line_out
);
    // Bus idles high through the pull-up
    initial line_out = 1'b1;

    // Stop level is a caller choice so a bad stop bit can be provoked
    task automatic send(input logic [7:0] data, input logic stop, input int bclk);
        logic [9:0] frame;
        frame = {stop, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out = frame[i];
            repeat (bclk) @(negedge clock);
        end
        // Only a bad stop bit needs the line restored; one clock of idle after it
        if (stop !== 1'b1) begin
            line_out = 1'b1;
            @(negedge clock);
        end
    endtask

    // Listens whatever the driver enable says, as an auto-turnaround node
    task automatic receive(output logic [9:0] frame, input int bclk);
        int n;
        frame = '1;
        for (n = 0; n < 40 * bclk && tx_line !== 1'b0; n++) @(negedge clock);
        repeat (bclk / 2) @(negedge clock);
        for (int i = 0; i < 10; i++) begin
            frame[i] = tx_line;
            if (i < 9) repeat (bclk) @(negedge clock);
        end
    endtask
endmodule
`default_nettype wire

// *** sim/rs485_serial_port_test.sv ***
// Self-checking bench for the two-wire serial port with one partner node.
// Assumes divisor 5 (80 clocks a bit) unless a scenario changes it.
`timescale 1ns/100ps
`default_nettype none
module rs485_serial_port_test;
    import rsp_pkg::*;
    logic             clock;
    logic             rst_b;
    logic [DIV_W-1:0] baud_divisor;
    logic             master_mode;
    logic             buffered_mode;
    logic             turnaround;
    logic             rx_line;
    logic             tx_line;
    logic             driver_enable;
    logic             tx_valid;
    logic [7:0]       tx_data;
    logic             tx_ready;
    logic             rx_valid;
    logic [7:0]       rx_data;
    logic             rx_ready;
    logic             rx_framing_error;
    logic             rx_overrun;
    int               error_cnt = 0;
    int               check_count = 0;
    int               cycles = 0;
    int               bclk = 80;
    logic [9:0]       frame;
    logic [7:0]       got;

    rsp_serial_port dut (
        .clock(clock), .rst_b(rst_b), .baud_divisor(baud_divisor),
        .master_mode(master_mode), .buffered_mode(buffered_mode), .turnaround(turnaround),
        .serial_receive_line(rx_line), .serial_transmit_line(tx_line),
        .driver_enable(driver_enable), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .rx_framing_error(rx_framing_error), .rx_overrun(rx_overrun)
    );
    rsp_node_model node (.clock(clock), .tx_line(tx_line), .line_out(rx_line));

    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Hang guard; generous over the expected run of about 14k cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Offer one byte and hold it until the accepting edge
    task automatic send_tx(input logic [7:0] d);
        for (int n = 0; n < 2000 && tx_ready !== 1'b1; n++) @(negedge clock);
        tx_valid = 1'b1;
        tx_data = d;
        @(negedge clock);
        tx_valid = 1'b0;
    endtask

    // Pop one byte; a missing byte shows as all-ones with a mismatch counted
    task automatic pop(output logic [7:0] d);
        for (int n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(negedge clock);
        d = (rx_valid === 1'b1) ? rx_data : 8'hFF;
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
        // Let an edge pass so a following pop does not re-raise ready at once
        @(negedge clock);
    endtask

    task automatic t_tx_frames();
        logic [7:0] v [3] = '{8'hA5, 8'h01, 8'h80};
        turnaround = 1'b1;
        foreach (v[i]) begin
            send_tx(v[i]);
            node.receive(frame, bclk);
            check(frame, {1'b1, v[i], 1'b0});
        end
    endtask

    task automatic t_driver();
        turnaround = 1'b0;
        repeat (2) @(negedge clock);
        check(driver_enable, 1'b0);
        turnaround = 1'b1;
        repeat (2) @(negedge clock);
        check(driver_enable, 1'b1);
        master_mode = 1'b1;
        turnaround = 1'b0;
        send_tx(8'h0F);
        repeat (bclk * 3) @(negedge clock);
        check(driver_enable, 1'b1);
        repeat (bclk * 9) @(negedge clock);
        check(driver_enable, 1'b0);
        master_mode = 1'b0;
        turnaround = 1'b1;
    endtask

    task automatic t_rx_single();
        node.send(8'h3C, 1'b1, bclk);
        pop(got);
        check(got, 8'h3C);
    endtask

    task automatic t_duplex();
        fork
            begin
                send_tx(8'h5A);
                node.receive(frame, bclk);
            end
            node.send(8'hC3, 1'b1, bclk);
        join
        check(frame, {1'b1, 8'h5A, 1'b0});
        pop(got);
        check(got, 8'hC3);
    endtask

    task automatic t_overrun();
        node.send(8'h11, 1'b1, bclk);
        node.send(8'h22, 1'b1, bclk);
        check(rx_overrun, 1'b1);
        pop(got);
        check(got, 8'h11);
        check(rx_valid, 1'b0);
    endtask

    task automatic t_framing();
        node.send(8'h77, 1'b0, bclk);
        repeat (bclk) @(negedge clock);
        check(rx_framing_error, 1'b1);
        check(rx_valid, 1'b0);
    endtask

    // Reset mid-frame must put the line outputs and all handshake and error flags (not rx_data) back to idle
    task automatic t_reset();
        send_tx(8'h00);
        repeat (bclk * 3) @(negedge clock);
        rst_b = 1'b0;
        @(negedge clock);
        check({tx_line, driver_enable, tx_ready}, 3'b101);
        check({rx_valid, rx_framing_error, rx_overrun}, 3'b000);
        rst_b = 1'b1;
        @(negedge clock);
    endtask

    task automatic t_buffered();
        logic [7:0] v [3] = '{8'hE1, 8'h2D, 8'h96};
        buffered_mode = 1'b1;
        foreach (v[i]) node.send(v[i], 1'b1, bclk);
        foreach (v[i]) begin
            pop(got);
            check(got, v[i]);
        end
        check(rx_overrun, 1'b0);
    endtask

    // Half the top rate: 160 clocks a bit both ways
    task automatic t_slow();
        baud_divisor = 16'h000A;
        bclk = 160;
        send_tx(8'hB4);
        node.receive(frame, bclk);
        check(frame, {1'b1, 8'hB4, 1'b0});
        node.send(8'h4B, 1'b1, bclk);
        pop(got);
        check(got, 8'h4B);
        // Below the floor the divisor clamps back to the top rate
        baud_divisor = 16'h0002;
        bclk = 80;
        send_tx(8'hC6);
        node.receive(frame, bclk);
        check(frame, {1'b1, 8'hC6, 1'b0});
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        baud_divisor = 16'h0005;
        master_mode = 1'b0;
        buffered_mode = 1'b0;
        turnaround = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        t_tx_frames();
        t_driver();
        t_rx_single();
        t_duplex();
        t_overrun();
        t_framing();
        t_reset();
        t_buffered();
        t_slow();
        close_out();
    end
endmodule
`default_nettype wire
